/* File: hdl/analog_output_control_cfg.svh */
`ifndef ANALOG_OUTPUT_CONTROL_CFG_SVH
`define ANALOG_OUTPUT_CONTROL_CFG_SVH

// Register byte addresses
`define REG_LEVEL0 16'h03e8
`define REG_LEVEL1 16'h03ec
`define REG_SQ_ENABLE 16'hf05c
`define REG_PU_LEVEL0 16'h0100
`define REG_PU_LEVEL1 16'h0104
`define REG_PU_ENABLE 16'h0108
`define REG_STREAM_OUT 16'h010c
`define REG_STATUS 16'h0110

// Field positions
`define SQ_ENABLE_BIT 0
`define STREAM_EN_BIT 0
`define STREAM_TGT_BIT 1
`define STAT_RUN_BIT 0
`define STAT_SQ_BIT 1

// Reset values
`define PU_LEVEL_RST 32'h00000000
`define PU_ENABLE_RST 2'h3

// Timing
`define CLK_HZ 200000000
`define STARTUP_MS 100
`define SQ_FREQ_HZ 10
`define STARTUP_CYC (`CLK_HZ / 1000 * `STARTUP_MS)
`define SQ_HALF_CYC (`CLK_HZ / (2 * `SQ_FREQ_HZ))
`define CNT_W 25

// Converter and float constants
`define CODE_BITS 12
`define FULL_SCALE_F32 32'h40a00000
`define SQ_HIGH_F32 32'h40533333
`define ZERO_F32 32'h00000000
`define SCALE_Q16 32'h03330000
`define EXP_SHIFT_BASE 8'd165
`define EXP_MIN 8'd100

`endif

/* File: hdl/analog_output_control_pkg.sv */
`include "analog_output_control_cfg.svh"

package analog_output_control_pkg;

  typedef logic [`CODE_BITS-1:0] code_t;

  typedef enum logic {
    PH_FACTORY,
    PH_RUN
  } phase_t;

  typedef struct packed {
    phase_t phase;
    logic [`CNT_W-1:0] start_cnt;
    logic [1:0][31:0] level_f;
    logic [1:0][`CODE_BITS-1:0] code;
    logic [1:0] en;
    logic [1:0][31:0] pu_f;
    logic [1:0][`CODE_BITS-1:0] pu_code;
    logic [1:0] pu_en;
    logic [1:0] written;
    logic sq_on;
    logic sq_lvl;
    logic [`CNT_W-1:0] sq_cnt;
    logic [1:0] stream;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [`CODE_BITS-1:0] out_code0;
    logic [`CODE_BITS-1:0] out_code1;
    logic [1:0] out_en;
  } state_t;

endpackage : analog_output_control_pkg

/* File: hdl/float_to_code.sv */
`include "analog_output_control_cfg.svh"

module float_to_code
  import analog_output_control_pkg::*;
(
  input wire logic [31:0] value,   // Requested voltage, float32
  output logic [`CODE_BITS-1:0] code,  // Nearest converter code
  output logic [31:0] clamped      // Value to read back
);

  logic sign;
  logic [7:0] expo;
  logic [55:0] prod;
  logic [7:0] sh;
  logic [55:0] shifted;
  logic [13:0] half;
  logic [12:0] rounded;

  // Mantissa times codes-per-volt, then scaled by exponent with rounding
  always_comb begin
    sign = value[31];
    expo = value[30:23];
    prod = 56'({1'b1, value[22:0]}) * 56'(`SCALE_Q16);
    sh = 8'(`EXP_SHIFT_BASE - expo);
    shifted = prod >> sh;
    half = shifted[13:0] + 14'h1;
    rounded = half[13:1];
    code = '0;
    clamped = value;
    if (sign) begin
      clamped = `ZERO_F32;
    end else if (value >= `FULL_SCALE_F32) begin
      // Positive floats order like unsigned integers, so a plain compare works
      code = '1;
      clamped = `FULL_SCALE_F32;
    end else if (expo >= `EXP_MIN) begin
      code = (rounded > 13'({`CODE_BITS{1'b1}})) ? '1 : rounded[`CODE_BITS-1:0];
    end
  end

endmodule : float_to_code

/* File: hdl/analog_output_control.sv */
// Functional notes
// - Two independent output channels, zero to about five volts, 12 bit codes.
// - Per-channel float32 level register from address 1000, read/write, write sets output.
// - Writing above reach reads back the real full-scale voltage instead.
// - Power-up state configurable; factory default is both enabled at zero volts.
// - Factory state held about 100 ms after power-up, then user state applied.
// - Write 1 at 61532 starts 10 Hz 3.3 V square wave on second output; 0 stops.
// - Any write to the second channel level cancels the square wave.
// - Enabling stream-out aimed at the second output cancels the square wave.
`include "analog_output_control_cfg.svh"

module analog_output_control
  import analog_output_control_pkg::*;
#(
  parameter int STARTUP_CYC = `STARTUP_CYC,  // Factory hold after reset
  parameter int SQ_HALF_CYC = `SQ_HALF_CYC   // Half period of square wave
) (
  input wire logic clk,                       // 200 MHz clock
  input wire logic rst,                       // Async reset, active high
  input wire logic psel,                      // APB select
  input wire logic penable,                   // APB access phase
  input wire logic pwrite,                    // APB direction
  input wire logic [15:0] paddr,              // APB byte address
  input wire logic [31:0] pwdata,             // APB write data
  output logic [31:0] prdata,                 // APB read data
  output logic pready,                        // APB ready
  output logic pslverr,                       // APB error on unmapped address
  output logic [`CODE_BITS-1:0] out_code0,    // First channel converter code
  output logic [`CODE_BITS-1:0] out_code1,    // Second channel converter code
  output logic [1:0] out_enable               // Channel output enables
);

  localparam logic [`CNT_W-1:0] START_LAST = `CNT_W'(STARTUP_CYC - 1);
  localparam logic [`CNT_W-1:0] SQ_LAST = `CNT_W'(SQ_HALF_CYC - 1);

  localparam state_t RESET_STATE = '{
    phase: PH_FACTORY,
    start_cnt: '0,
    level_f: '0,
    code: '0,
    en: 2'h3,
    pu_f: {`PU_LEVEL_RST, `PU_LEVEL_RST},
    pu_code: '0,
    pu_en: `PU_ENABLE_RST,
    written: '0,
    sq_on: 1'b0,
    sq_lvl: 1'b0,
    sq_cnt: '0,
    stream: '0,
    pready: 1'b0,
    pslverr: 1'b0,
    prdata: '0,
    out_code0: '0,
    out_code1: '0,
    out_en: 2'h3
  };

  state_t r;
  state_t s;
  logic [`CODE_BITS-1:0] wr_code;
  logic [31:0] wr_clamped;
  logic [`CODE_BITS-1:0] sq_code;
  logic mapped;
  logic wr;
  logic ch;

  // Conversion of the bus write data, used by every level register
  float_to_code u_wr_conv (
    .value(pwdata),
    .code(wr_code),
    .clamped(wr_clamped)
  );

  // Constant conversion of the square wave high level
  float_to_code u_sq_conv (
    .value(`SQ_HIGH_F32),
    .code(sq_code),
    .clamped()
  );

  // Address decode; anything else answers with an error
  always_comb begin
    case (paddr)
      `REG_LEVEL0, `REG_LEVEL1, `REG_SQ_ENABLE, `REG_PU_LEVEL0, `REG_PU_LEVEL1,
      `REG_PU_ENABLE, `REG_STREAM_OUT, `REG_STATUS: begin
        mapped = 1'b1;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // Next-state logic for the whole block
  always_comb begin
    s = r;
    ch = 1'b0;
    // One wait state: ready rises in the second access cycle, write lands there
    s.pready = psel & penable & ~r.pready;
    s.pslverr = 1'b0;
    s.prdata = '0;
    wr = psel & penable & r.pready & pwrite & mapped;

    if (s.pready) begin
      s.pslverr = ~mapped;
      if (!pwrite) begin
        case (paddr)
          `REG_LEVEL0: s.prdata = r.level_f[0];
          `REG_LEVEL1: s.prdata = r.level_f[1];
          `REG_PU_LEVEL0: s.prdata = r.pu_f[0];
          `REG_PU_LEVEL1: s.prdata = r.pu_f[1];
          `REG_PU_ENABLE: s.prdata = {30'h0, r.pu_en};
          `REG_STREAM_OUT: s.prdata = {30'h0, r.stream};
          `REG_STATUS: begin
            s.prdata[`STAT_RUN_BIT] = (r.phase == PH_RUN);
            s.prdata[`STAT_SQ_BIT] = r.sq_on;
          end
          default: s.prdata = '0;  // Write-only enable reads as zero
        endcase
      end
    end

    case (r.phase)
      PH_FACTORY: begin
        s.start_cnt = r.start_cnt + `CNT_W'(1);
        if (r.start_cnt == START_LAST) begin
          s.phase = PH_RUN;
          for (int i = 0; i < 2; i++) begin
            if (!r.written[i]) begin
              s.level_f[i] = r.pu_f[i];
              s.code[i] = r.pu_code[i];
              s.en[i] = r.pu_en[i];
            end
          end
        end
      end
      PH_RUN: begin
        s.start_cnt = r.start_cnt;
      end
      default: begin
        s.phase = PH_FACTORY;
      end
    endcase

    // Square wave timebase; free-runs only while the mode is on
    if (r.sq_on) begin
      if (r.sq_cnt == SQ_LAST) begin
        s.sq_cnt = '0;
        s.sq_lvl = ~r.sq_lvl;
      end else begin
        s.sq_cnt = r.sq_cnt + `CNT_W'(1);
      end
    end

    // Register writes; applied after the timer so software wins a tie
    if (wr) begin
      case (paddr)
        `REG_LEVEL0, `REG_LEVEL1: begin
          ch = paddr[2];
          s.level_f[ch] = wr_clamped;
          s.code[ch] = wr_code;
          s.en[ch] = 1'b1;
          // Remember early writes so the power-up load does not undo them
          if (r.phase == PH_FACTORY) begin
            s.written[ch] = 1'b1;
          end
          if (ch) begin
            s.sq_on = 1'b0;
          end
        end
        `REG_SQ_ENABLE: begin
          s.sq_on = pwdata[`SQ_ENABLE_BIT];
          s.sq_lvl = 1'b1;
          s.sq_cnt = '0;
        end
        `REG_PU_LEVEL0, `REG_PU_LEVEL1: begin
          ch = paddr[2];
          s.pu_f[ch] = wr_clamped;
          s.pu_code[ch] = wr_code;
        end
        `REG_PU_ENABLE: begin
          s.pu_en = pwdata[1:0];
        end
        `REG_STREAM_OUT: begin
          s.stream = pwdata[1:0];
          if (pwdata[`STREAM_EN_BIT] && pwdata[`STREAM_TGT_BIT]) begin
            s.sq_on = 1'b0;
          end
        end
        default: begin
          s.stream = s.stream;
        end
      endcase
    end

    if (s.phase == PH_FACTORY) begin
      s.out_code0 = '0;
      s.out_code1 = '0;
      s.out_en = 2'h3;
    end else begin
      s.out_code0 = s.code[0];
      s.out_en = s.en;
      if (s.sq_on) begin
        s.out_code1 = s.sq_lvl ? sq_code : '0;
        s.out_en[1] = 1'b1;
      end else begin
        s.out_code1 = s.code[1];
      end
    end
  end

  // Single state register; outputs are fields of it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r <= RESET_STATE;
    end else begin
      r <= s;
    end
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign out_code0 = r.out_code0;
  assign out_code1 = r.out_code1;
  assign out_enable = r.out_en;

endmodule : analog_output_control

/* File: dv/analog_output_control_monitor.sv */
`include "analog_output_control_cfg.svh"
module analog_output_control_monitor
  import analog_output_control_pkg::*;
#(
  parameter int STARTUP_CYC = 50 // Factory hold length
) (
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Access
  input wire logic pwrite, // Direction
  input wire logic [15:0] paddr, // Address
  input wire logic [31:0] pwdata, // Write data
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic [`CODE_BITS-1:0] out_code0, // Code 0
  input wire logic [`CODE_BITS-1:0] out_code1, // Code 1
  input wire logic [1:0] out_enable // Enables
);
  logic [31:0] age;
  logic live;
  logic wr;
  logic mapped;
  // Cycles since reset, saturating so late checks never wrap back into the hold
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      age <= 32'h0;
    end else if (age != 32'hffffffff) begin
      age <= age + 32'h1;
    end
  end
  // Qualifiers: a committed write, past the hold, to a known place
  assign live = age > 32'(STARTUP_CYC + 2);
  assign wr = psel & penable & pready & pwrite;
  assign mapped = paddr inside {`REG_LEVEL0, `REG_LEVEL1, `REG_SQ_ENABLE, `REG_PU_LEVEL0,
    `REG_PU_LEVEL1, `REG_PU_ENABLE, `REG_STREAM_OUT, `REG_STATUS};
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_ready_wait;
    psel && penable && !pready |=> pready;
  endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("ready late");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held");
  property p_err;
    pready |-> pslverr == !mapped;
  endproperty
  a_err: assert property (p_err) else $error("error flag wrong");
  property p_rdata_idle;
    !(pready && !pwrite) |-> prdata == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data leak");
  property p_hold;
    age < 32'(STARTUP_CYC - 1) |-> out_code0 == '0 && out_code1 == '0 && out_enable == 2'h3;
  endproperty
  a_hold: assert property (p_hold) else $error("hold not factory");
  property p_full;
    wr && live && paddr == `REG_LEVEL0 && pwdata == 32'h40c00000 |-> ##[1:2] out_code0 == 12'hfff;
  endproperty
  a_full: assert property (p_full) else $error("no full scale");
  property p_neg;
    wr && live && paddr == `REG_LEVEL0 && pwdata[31] |-> ##[1:2] out_code0 == '0 && out_enable[0];
  endproperty
  a_neg: assert property (p_neg) else $error("negative not clamped");
  property p_sq_on;
    wr && live && paddr == `REG_SQ_ENABLE && pwdata[0] |-> ##[1:2] out_code1 == 12'ha8f;
  endproperty
  a_sq_on: assert property (p_sq_on) else $error("square not high");
  property p_sq_cut;
    wr && live && paddr == `REG_LEVEL1 && pwdata == 32'h3f800000 |-> ##[1:2] out_code1 == 12'h333;
  endproperty
  a_sq_cut: assert property (p_sq_cut) else $error("level write lost");
endmodule : analog_output_control_monitor

bind analog_output_control analog_output_control_monitor #(.STARTUP_CYC(STARTUP_CYC))
  analog_output_control_monitor_inst (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .out_code0(out_code0), .out_code1(out_code1), .out_enable(out_enable));

/* File: dv/test_analog_output_control.sv */
`include "analog_output_control_cfg.svh"
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin bad_count++; \
  $display("unexpected %s exp %h got %h", nm, ex, got); end end
module test_analog_output_control
  import analog_output_control_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int STARTUP = 50;
  localparam int SQ_HALF = 8;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  code_t out_code0;
  code_t out_code1;
  logic [1:0] out_enable;
  logic [31:0] rdv;
  logic erv;
  int bad_count = 0;
  int compares = 0;
  int cyc = 0;
  analog_output_control #(.STARTUP_CYC(STARTUP), .SQ_HALF_CYC(SQ_HALF)) analog_output_control_inst (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .out_code0(out_code0), .out_code1(out_code1), .out_enable(out_enable));
  // Clock, and a ceiling well above the few hundred cycles the tests need
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      bad_count++;
      print_verdict();
    end
  end
  // One transfer; the wait ends only when ready shows, never after a fixed count
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Ready, read data and error are all taken at the edge that completes the access
    do @(posedge clk); while (pready !== 1'b1);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic t_hold;
    `CHK("enable", 2'h3, out_enable)
    apb(1'b0, `REG_PU_ENABLE, 32'h0);
    `CHK("pu_enable", 32'h3, rdv)
    apb(1'b1, `REG_PU_LEVEL1, 32'h3f800000);
    apb(1'b1, `REG_LEVEL0, 32'h3f800000);
    @(negedge clk);
    `CHK("held code0", 12'h000, out_code0)
    apb(1'b0, `REG_STATUS, 32'h0);
    `CHK("done early", 1'b0, rdv[0])
    repeat (STARTUP) @(negedge clk);
    `CHK("code0", 12'h333, out_code0)
    `CHK("code1", 12'h333, out_code1)
    apb(1'b0, `REG_STATUS, 32'h0);
    `CHK("done", 1'b1, rdv[0])
    $display("test hold done");
  endtask : t_hold
  task automatic t_level;
    logic [31:0] vin[3] = '{32'h40c00000, 32'hbf800000, 32'h3f800000};
    logic [31:0] vrb[3] = '{32'h40a00000, 32'h0, 32'h3f800000};
    logic [11:0] vcd[3] = '{12'hfff, 12'h000, 12'h333};
    for (int ch = 0; ch < 2; ch++) begin
      for (int i = 0; i < 3; i++) begin
        apb(1'b1, `REG_LEVEL0 + 16'(4 * ch), vin[i]);
        apb(1'b0, `REG_LEVEL0 + 16'(4 * ch), 32'h0);
        `CHK("readback", vrb[i], rdv)
        `CHK("code", vcd[i], ch ? out_code1 : out_code0)
      end
    end
    `CHK("other channel", 12'h333, out_code0)
    $display("test level done");
  endtask : t_level
  task automatic t_square;
    logic [15:0] ca[4] = '{`REG_STREAM_OUT, `REG_STREAM_OUT, `REG_LEVEL1, `REG_SQ_ENABLE};
    logic [31:0] cd[4] = '{32'h1, 32'h3, 32'h3f800000, 32'h0};
    logic exp_on[4] = '{1'b1, 1'b0, 1'b0, 1'b0};
    int n;
    apb(1'b1, `REG_SQ_ENABLE, 32'h1);
    repeat (2) @(negedge clk);
    `CHK("square high", 12'ha8f, out_code1)
    n = 0;
    while (out_code1 === 12'ha8f && n < 20) begin
      @(negedge clk);
      n++;
    end
    `CHK("half period", SQ_HALF - 1, n)
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, `REG_SQ_ENABLE, 32'h1);
      apb(1'b1, ca[i], cd[i]);
      apb(1'b0, `REG_STATUS, 32'h0);
      `CHK("square active", exp_on[i], rdv[1])
    end
    apb(1'b0, `REG_SQ_ENABLE, 32'h0);
    `CHK("write only", 32'h0, rdv)
    $display("test square done");
  endtask : t_square
  task automatic t_unmapped;
    apb(1'b1, 16'h0200, 32'hffffffff);
    `CHK("err write", 1'b1, erv)
    apb(1'b0, 16'h0200, 32'h0);
    `CHK("err read", 1'b1, erv)
    `CHK("err data", 32'h0, rdv)
    $display("test unmapped done");
  endtask : t_unmapped
  task automatic print_verdict;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict
  // Reset for five cycles, then the tests in order
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_hold();
    t_level();
    t_square();
    t_unmapped();
    print_verdict();
  end
endmodule : test_analog_output_control
